// file: hdl/fdr_register_bank.sv
// fan driver register bank: holding/input registers, link timeout, fault classes
// What this block does
// - line rate register, 96 or 192, default 96
// - framing code 0..2, default two stop bits
// - loop reference 0..100, used in mode 12
// - three loop gains 0..32767, reset zero
// - loop period in ms 0..32767, reset zero
// - threshold flag when speed exceeds nonzero threshold
// - link timeout in seconds stops fan, alarms
// - timeout value zero disables link supervision
// - speed reference starts at minimum, ramps up
// - overtemperature stops, alarm clears when cooled
// - temperature threshold readable at holding 29
// - raw analog inputs reported as 16-bit codes
// - fault given by two alarm registers together
// - blocking fault stops until reset command
// - auto-restart fault retries after some seconds
// - thirty-three read-only input registers
// - firmware, driver model, fan model registers
// - link loss reported as 4/255, blocking
// - writing 1 to holding 0 resets faults
`timescale 1ns/10ps
`default_nettype none
module fdr_register_bank #(
  parameter logic [15:0] FW_VERSION = 16'h0100,
  parameter logic [15:0] DRIVER_MODEL = 16'h1234,
  parameter logic [15:0] FAN_MODEL = 16'h0001,
  parameter logic [15:0] TEMP_LIMIT = 16'h0320,
  parameter int unsigned SECOND_CYCLES = fdr_pkg::CYCLES_PER_SECOND,
  parameter int unsigned RESTART_CYCLES = fdr_pkg::RESTART_DELAY_S * fdr_pkg::CYCLES_PER_SECOND,
  parameter int unsigned RAMP_CYCLES = fdr_pkg::RAMP_STEP_CYCLES
) (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire fdr_pkg::fdr_req_t REQ_I,
  input wire logic LINK_ACTIVITY_I,
  input wire fdr_pkg::fdr_telem_t TELEM_I,
  input wire logic FAULT_BLOCK_I,
  input wire logic FAULT_AUTO_I,
  input wire logic [15:0] FAULT_CODE_I,
  input wire logic DERATE_FAILED_I,
  output logic [15:0] RDATA_O,
  output logic RVALID_O,
  output logic WERR_O,
  output logic [15:0] LINE_RATE_O,
  output logic [15:0] FRAMING_O,
  output logic [15:0] LOOP_REF_O,
  output logic LOOP_REF_ACTIVE_O,
  output logic [15:0] GAIN_P_O,
  output logic [15:0] GAIN_I_O,
  output logic [15:0] GAIN_D_O,
  output logic [15:0] LOOP_PERIOD_O,
  output logic [15:0] SPEED_REF_O,
  output logic THRESHOLD_O,
  output logic DERATE_O,
  output logic MOTOR_RUN_O,
  output logic ALARM_O
);
  logic [15:0] line_rate;
  logic [15:0] framing;
  logic [15:0] loop_ref;
  logic [15:0] gain_p;
  logic [15:0] gain_i;
  logic [15:0] gain_d;
  logic [15:0] loop_period;
  logic [15:0] speed_thr;
  logic [15:0] link_timeout;
  logic [15:0] mode_sel;
  logic [15:0] fault_pri;
  logic [15:0] fault_sec;
  logic [15:0] speed_ref;
  logic [15:0] secs;
  logic [31:0] sec_div;
  logic [31:0] wait_cnt;
  logic [31:0] ramp_cnt;
  logic act_s1;
  logic act_s2;
  logic blk_s1;
  logic blk_s2;
  logic aut_s1;
  logic aut_s2;
  logic drf_s1;
  logic drf_s2;
  fdr_pkg::fdr_state_t state;
  fdr_pkg::fdr_state_t next_state;

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] hi);
    in_range = (v <= hi);
  endfunction

  wire hold_wr = REQ_I.wr && !REQ_I.input_space;
  wire wr_rate = hold_wr && (REQ_I.addr == fdr_pkg::HR_LINE_RATE);
  wire wr_frame = hold_wr && (REQ_I.addr == fdr_pkg::HR_FRAMING);
  wire wr_ref = hold_wr && (REQ_I.addr == fdr_pkg::HR_LOOP_REF);
  wire wr_gp = hold_wr && (REQ_I.addr == fdr_pkg::HR_GAIN_P);
  wire wr_gi = hold_wr && (REQ_I.addr == fdr_pkg::HR_GAIN_I);
  wire wr_gd = hold_wr && (REQ_I.addr == fdr_pkg::HR_GAIN_D);
  wire wr_per = hold_wr && (REQ_I.addr == fdr_pkg::HR_LOOP_PERIOD);
  wire wr_thr = hold_wr && (REQ_I.addr == fdr_pkg::HR_SPEED_THR);
  wire wr_tmo = hold_wr && (REQ_I.addr == fdr_pkg::HR_LINK_TIMEOUT);
  wire wr_mode = hold_wr && (REQ_I.addr == fdr_pkg::HR_MODE_SELECT);
  wire wr_rst = hold_wr && (REQ_I.addr == fdr_pkg::HR_FAULT_RESET);
  wire ok_rate = (REQ_I.wdata == fdr_pkg::RATE_9K6) || (REQ_I.wdata == fdr_pkg::RATE_19K2);
  wire ok_frame = in_range(REQ_I.wdata, fdr_pkg::FRAME_ODD);
  wire ok_ref = in_range(REQ_I.wdata, fdr_pkg::LOOP_REF_MAX);
  // gain range, also used for period
  wire ok_gain = in_range(REQ_I.wdata, fdr_pkg::GAIN_MAX);
  wire ok_thr = in_range(REQ_I.wdata, TELEM_I.speed_max);
  wire ok_mode = in_range(REQ_I.wdata, fdr_pkg::MODE_MAX);
  wire ok_rst = (REQ_I.wdata == fdr_pkg::RESET_CMD);
  wire ok_tmo = in_range(REQ_I.wdata, fdr_pkg::TIMEOUT_MAX);
  wire known_hold = wr_rate | wr_frame | wr_ref | wr_gp | wr_gi | wr_gd | wr_per | wr_thr | wr_tmo | wr_mode | wr_rst;
  // read-only and unmapped holding numbers fall out as unknown and are refused
  wire bad_space = REQ_I.wr && (REQ_I.input_space || !known_hold);
  wire bad_cfg = (wr_rate && !ok_rate) || (wr_frame && !ok_frame) || (wr_ref && !ok_ref);
  wire bad_loop = (wr_gp | wr_gi | wr_gd | wr_per) && !ok_gain;
  wire bad_misc = (wr_thr && !ok_thr) || (wr_tmo && !ok_tmo) || (wr_mode && !ok_mode) || (wr_rst && !ok_rst);
  wire bad_wr = bad_space || bad_cfg || bad_loop || bad_misc;
  wire fault_reset = wr_rst && ok_rst;

  // pins from the motor side are asynchronous to the bus logic
  always_ff @(posedge SYS_CLK_I) begin
    act_s1 <= LINK_ACTIVITY_I;
    act_s2 <= act_s1;
    blk_s1 <= FAULT_BLOCK_I;
    blk_s2 <= blk_s1;
    aut_s1 <= FAULT_AUTO_I;
    aut_s2 <= aut_s1;
    drf_s1 <= DERATE_FAILED_I;
    drf_s2 <= drf_s1;
  end

  // holding registers: a refused value leaves the old one in place
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) line_rate <= fdr_pkg::RATE_9K6;
    else if (wr_rate && ok_rate) line_rate <= REQ_I.wdata;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) framing <= fdr_pkg::FRAME_2STOP;
    else if (wr_frame && ok_frame) framing <= REQ_I.wdata;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) loop_ref <= fdr_pkg::ZERO16;
    else if (wr_ref && ok_ref) loop_ref <= REQ_I.wdata;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) gain_p <= fdr_pkg::ZERO16;
    else if (wr_gp && ok_gain) gain_p <= REQ_I.wdata;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) gain_i <= fdr_pkg::ZERO16;
    else if (wr_gi && ok_gain) gain_i <= REQ_I.wdata;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) gain_d <= fdr_pkg::ZERO16;
    else if (wr_gd && ok_gain) gain_d <= REQ_I.wdata;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) loop_period <= fdr_pkg::ZERO16;
    else if (wr_per && ok_gain) loop_period <= REQ_I.wdata;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) speed_thr <= fdr_pkg::ZERO16;
    else if (wr_thr && ok_thr) speed_thr <= REQ_I.wdata;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) link_timeout <= fdr_pkg::ZERO16;
    else if (wr_tmo && ok_tmo) link_timeout <= REQ_I.wdata;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) mode_sel <= fdr_pkg::MODE_RESET;
    else if (wr_mode && ok_mode) mode_sel <= REQ_I.wdata;
  end

  // seconds of link silence; any request or activity restarts it
  // reads count too, so a master that only polls keeps the fan running
  wire link_seen = REQ_I.wr || REQ_I.rd || act_s2;
  wire sec_tick = (sec_div == SECOND_CYCLES - 1);
  wire link_lost = (link_timeout != fdr_pkg::ZERO16) && (secs >= link_timeout) && (state == fdr_pkg::FDR_RUN);
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I || link_seen || state != fdr_pkg::FDR_RUN) begin
      sec_div <= 32'h00000000;
      secs <= fdr_pkg::ZERO16;
    end else if (sec_tick) begin
      sec_div <= 32'h00000000;
      if (secs != 16'hFFFF) secs <= secs + 16'h0001;
    end else begin
      sec_div <= sec_div + 32'h00000001;
    end
  end

  // overtemperature that derating could not cure
  wire overtemp = drf_s2 && (TELEM_I.mod_temp > TEMP_LIMIT);
  wire cooled = (TELEM_I.mod_temp < TEMP_LIMIT);
  wire retry_done = (wait_cnt >= RESTART_CYCLES - 1);

  always_comb begin
    next_state = state;
    case (state)
      fdr_pkg::FDR_RUN: begin
        if (blk_s2 || link_lost) next_state = fdr_pkg::FDR_BLOCKED;
        else if (aut_s2 || overtemp) next_state = fdr_pkg::FDR_RETRY;
      end
      fdr_pkg::FDR_BLOCKED: begin
        if (fault_reset) next_state = fdr_pkg::FDR_RUN;
      end
      fdr_pkg::FDR_RETRY: begin
        if (blk_s2) next_state = fdr_pkg::FDR_BLOCKED;
        else if (fault_reset) next_state = fdr_pkg::FDR_RUN;
        else if (fault_pri == fdr_pkg::FAULT_CLASS4 && fault_sec == fdr_pkg::FAULT_OVERTEMP) begin
          if (cooled) next_state = fdr_pkg::FDR_RUN;
        end else if (retry_done) next_state = fdr_pkg::FDR_RUN;
      end
      default: next_state = fdr_pkg::FDR_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      state <= fdr_pkg::FDR_RUN;
      fault_pri <= fdr_pkg::FAULT_NONE;
      fault_sec <= fdr_pkg::FAULT_NONE;
      wait_cnt <= 32'h00000000;
    end else begin
      state <= next_state;
      wait_cnt <= (state == fdr_pkg::FDR_RETRY) ? wait_cnt + 32'h00000001 : 32'h00000000;
      if (state == fdr_pkg::FDR_RUN && next_state != fdr_pkg::FDR_RUN) begin
        if (link_lost && !blk_s2) begin
          fault_pri <= fdr_pkg::FAULT_CLASS4;
          fault_sec <= fdr_pkg::FAULT_LINK_LOSS;
        end else if (overtemp && !blk_s2 && !aut_s2) begin
          fault_pri <= fdr_pkg::FAULT_CLASS4;
          fault_sec <= fdr_pkg::FAULT_OVERTEMP;
        end else begin
          fault_pri <= FAULT_CODE_I;
          fault_sec <= fdr_pkg::FAULT_NONE;
        end
      end else if (state == fdr_pkg::FDR_RETRY && next_state == fdr_pkg::FDR_BLOCKED) begin
        fault_pri <= FAULT_CODE_I;
        fault_sec <= fdr_pkg::FAULT_NONE;
      end else if (next_state == fdr_pkg::FDR_RUN && state != fdr_pkg::FDR_RUN) begin
        fault_pri <= fdr_pkg::FAULT_NONE;
        fault_sec <= fdr_pkg::FAULT_NONE;
      end
    end
  end

  // start at minimum speed, one rpm per ramp step
  wire ramp_tick = (ramp_cnt == RAMP_CYCLES - 1);
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I || state != fdr_pkg::FDR_RUN) begin
      speed_ref <= TELEM_I.speed_min;
      ramp_cnt <= 32'h00000000;
    end else begin
      ramp_cnt <= ramp_tick ? 32'h00000000 : ramp_cnt + 32'h00000001;
      if (ramp_tick && speed_ref < TELEM_I.speed_target) speed_ref <= speed_ref + 16'h0001;
      else if (ramp_tick && speed_ref > TELEM_I.speed_target) speed_ref <= TELEM_I.speed_target;
    end
  end

  logic [15:0] ir_data;
  always_comb begin
    case (REQ_I.addr)
      fdr_pkg::IR_FW_VERSION: ir_data = FW_VERSION;
      fdr_pkg::IR_DRIVER_MODEL: ir_data = DRIVER_MODEL;
      fdr_pkg::IR_SPEED_REF: ir_data = speed_ref;
      fdr_pkg::IR_MEAS_SPEED: ir_data = TELEM_I.meas_speed;
      fdr_pkg::IR_BUS_VOLT: ir_data = TELEM_I.bus_volt;
      fdr_pkg::IR_FAULT_PRI: ir_data = fault_pri;
      fdr_pkg::IR_MOTOR_CUR: ir_data = TELEM_I.motor_cur;
      fdr_pkg::IR_MOTOR_VOLT: ir_data = TELEM_I.motor_volt;
      fdr_pkg::IR_ANALOG_VOLT: ir_data = TELEM_I.analog_volt;
      fdr_pkg::IR_MOD_TEMP: ir_data = TELEM_I.mod_temp;
      fdr_pkg::IR_FAULT_SEC: ir_data = fault_sec;
      fdr_pkg::IR_ENABLE_RAW: ir_data = TELEM_I.enable_raw;
      fdr_pkg::IR_REF_RAW: ir_data = TELEM_I.ref_raw;
      fdr_pkg::IR_XDCR_RAW: ir_data = TELEM_I.xdcr_raw;
      fdr_pkg::IR_POWER: ir_data = TELEM_I.power;
      fdr_pkg::IR_IN_CUR: ir_data = TELEM_I.in_cur;
      default: ir_data = fdr_pkg::ZERO16;
    endcase
  end

  logic [15:0] hr_data;
  always_comb begin
    case (REQ_I.addr)
      fdr_pkg::HR_TEMP_LIMIT: hr_data = TEMP_LIMIT;
      fdr_pkg::HR_MODE_SELECT: hr_data = mode_sel;
      fdr_pkg::HR_FAN_MODEL: hr_data = FAN_MODEL;
      fdr_pkg::HR_LINE_RATE: hr_data = line_rate;
      fdr_pkg::HR_FRAMING: hr_data = framing;
      fdr_pkg::HR_LOOP_REF: hr_data = loop_ref;
      fdr_pkg::HR_GAIN_P: hr_data = gain_p;
      fdr_pkg::HR_GAIN_I: hr_data = gain_i;
      fdr_pkg::HR_GAIN_D: hr_data = gain_d;
      fdr_pkg::HR_LOOP_PERIOD: hr_data = loop_period;
      fdr_pkg::HR_SPEED_THR: hr_data = speed_thr;
      fdr_pkg::HR_LINK_TIMEOUT: hr_data = link_timeout;
      default: hr_data = fdr_pkg::ZERO16;
    endcase
  end

  wire [15:0] rd_word = REQ_I.input_space ? ir_data : hr_data;
  wire thr_hit = (speed_thr != fdr_pkg::ZERO16) && (TELEM_I.meas_speed > speed_thr);

  // registered read answer, one cycle after the request
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) RVALID_O <= 1'b0;
    else RVALID_O <= REQ_I.rd;
  end

  // data holds until the next read, so a slow master may take it late
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) RDATA_O <= fdr_pkg::ZERO16;
    else if (REQ_I.rd) RDATA_O <= rd_word;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) WERR_O <= 1'b0;
    else WERR_O <= bad_wr;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) THRESHOLD_O <= 1'b0;
    else THRESHOLD_O <= thr_hit;
  end

  assign LINE_RATE_O = line_rate;
  assign FRAMING_O = framing;
  assign LOOP_REF_O = loop_ref;
  // reference applies only in mode 12
  assign LOOP_REF_ACTIVE_O = (mode_sel == fdr_pkg::MODE_FIXED_LOOP);
  assign GAIN_P_O = gain_p;
  assign GAIN_I_O = gain_i;
  assign GAIN_D_O = gain_d;
  assign LOOP_PERIOD_O = loop_period;
  assign SPEED_REF_O = speed_ref;
  assign DERATE_O = (TELEM_I.mod_temp > TEMP_LIMIT);
  assign MOTOR_RUN_O = (state == fdr_pkg::FDR_RUN);
  assign ALARM_O = (state != fdr_pkg::FDR_RUN);
endmodule
`default_nettype wire

// file: hdl/fdr_pkg.sv
// package: register map, field codes and timing constants of the fan driver register bank
package fdr_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam logic [5:0] HR_FAULT_RESET = 6'h00;
  localparam logic [5:0] HR_TEMP_LIMIT = 6'h1D;
  localparam logic [5:0] HR_MODE_SELECT = 6'h22;
  localparam logic [5:0] HR_FAN_MODEL = 6'h2C;
  localparam logic [5:0] HR_LINE_RATE = 6'h2F;
  localparam logic [5:0] HR_FRAMING = 6'h30;
  localparam logic [5:0] HR_LOOP_REF = 6'h32;
  localparam logic [5:0] HR_GAIN_P = 6'h33;
  localparam logic [5:0] HR_GAIN_I = 6'h34;
  localparam logic [5:0] HR_GAIN_D = 6'h35;
  localparam logic [5:0] HR_LOOP_PERIOD = 6'h36;
  localparam logic [5:0] HR_SPEED_THR = 6'h37;
  localparam logic [5:0] HR_LINK_TIMEOUT = 6'h38;
  localparam logic [5:0] IR_FW_VERSION = 6'h00;
  localparam logic [5:0] IR_DRIVER_MODEL = 6'h01;
  localparam logic [5:0] IR_SPEED_REF = 6'h02;
  localparam logic [5:0] IR_MEAS_SPEED = 6'h03;
  localparam logic [5:0] IR_BUS_VOLT = 6'h09;
  localparam logic [5:0] IR_FAULT_PRI = 6'h0A;
  localparam logic [5:0] IR_MOTOR_CUR = 6'h0C;
  localparam logic [5:0] IR_MOTOR_VOLT = 6'h0D;
  localparam logic [5:0] IR_ANALOG_VOLT = 6'h0E;
  localparam logic [5:0] IR_MOD_TEMP = 6'h0F;
  localparam logic [5:0] IR_FAULT_SEC = 6'h11;
  localparam logic [5:0] IR_ENABLE_RAW = 6'h1C;
  localparam logic [5:0] IR_REF_RAW = 6'h1D;
  localparam logic [5:0] IR_XDCR_RAW = 6'h1E;
  localparam logic [5:0] IR_POWER = 6'h1F;
  localparam logic [5:0] IR_IN_CUR = 6'h20;
  localparam logic [5:0] IR_COUNT = 6'h21;
  localparam logic [15:0] RATE_9K6 = 16'h0060;
  localparam logic [15:0] RATE_19K2 = 16'h00C0;
  localparam logic [15:0] FRAME_2STOP = 16'h0000;
  localparam logic [15:0] FRAME_ODD = 16'h0002;
  localparam logic [15:0] LOOP_REF_MAX = 16'h0064;
  localparam logic [15:0] GAIN_MAX = 16'h7FFF;
  // longest link timeout, in seconds
  localparam logic [15:0] TIMEOUT_MAX = 16'h8078;
  localparam logic [15:0] MODE_FIXED_LOOP = 16'h000C;
  localparam logic [15:0] MODE_MAX = 16'h000C;
  localparam logic [15:0] MODE_RESET = 16'h0001;
  localparam logic [15:0] RESET_CMD = 16'h0001;
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_CLASS4 = 16'h0004;
  localparam logic [15:0] FAULT_LINK_LOSS = 16'h00FF;
  localparam logic [15:0] FAULT_OVERTEMP = 16'h0071;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned CYCLES_PER_SECOND = SECOND_NS / CLK_NS;
  localparam int unsigned RESTART_DELAY_S = 5;
  localparam int unsigned RAMP_STEP_MS = 1;
  localparam int unsigned RAMP_STEP_CYCLES = RAMP_STEP_MS * (CYCLES_PER_SECOND / 1000);

  typedef enum logic [2:0] {
    FDR_RUN = 3'b001,
    FDR_BLOCKED = 3'b010,
    FDR_RETRY = 3'b100
  } fdr_state_t;

  // one register access on the serial field-bus side
  typedef struct packed {
    logic wr;
    logic rd;
    logic input_space;
    logic [5:0] addr;
    logic [15:0] wdata;
  } fdr_req_t;

  // live telemetry from motor control
  typedef struct packed {
    logic [15:0] speed_target;
    logic [15:0] speed_min;
    logic [15:0] speed_max;
    logic [15:0] meas_speed;
    logic [15:0] bus_volt;
    logic [15:0] motor_cur;
    logic [15:0] motor_volt;
    logic [15:0] analog_volt;
    logic [15:0] mod_temp;
    logic [15:0] enable_raw;
    logic [15:0] ref_raw;
    logic [15:0] xdcr_raw;
    logic [15:0] power;
    logic [15:0] in_cur;
  } fdr_telem_t;
endpackage

// file: dv/fdr_register_bank_assertions.sv
// checker: port assertions of the fan driver register bank
`timescale 1ns/10ps
`default_nettype none
module fdr_register_bank_assertions #(
  parameter logic [15:0] TEMP_LIMIT = 16'h0320
) (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire fdr_pkg::fdr_req_t REQ_I,
  input wire fdr_pkg::fdr_telem_t TELEM_I,
  input wire logic FAULT_BLOCK_I,
  input wire logic RVALID_O,
  input wire logic WERR_O,
  input wire logic [15:0] LINE_RATE_O,
  input wire logic [15:0] FRAMING_O,
  input wire logic [15:0] LOOP_REF_O,
  input wire logic [15:0] SPEED_REF_O,
  input wire logic DERATE_O,
  input wire logic MOTOR_RUN_O,
  input wire logic ALARM_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!NRST_I);
  wire logic rate_wr = REQ_I.wr && !REQ_I.input_space && REQ_I.addr == 6'h2F && REQ_I.wdata == 16'h00C0;
  wire logic rst_wr = REQ_I.wr && !REQ_I.input_space && REQ_I.addr == 6'h00 && REQ_I.wdata == 16'h0001;
  a_read_answer: assert property (REQ_I.rd |=> RVALID_O) else $error("read not answered");
  a_input_refused: assert property (REQ_I.wr && REQ_I.input_space |=> WERR_O) else $error("input write taken");
  a_rate_reset: assert property ($rose(NRST_I) |-> LINE_RATE_O == 16'h0060 && FRAMING_O == 16'h0000)
    else $error("serial defaults wrong");
  a_rate_write: assert property (rate_wr |=> LINE_RATE_O == 16'h00C0 && !WERR_O) else $error("rate write lost");
  a_field_range: assert property (FRAMING_O <= 16'h0002 && LOOP_REF_O <= 16'h0064)
    else $error("field out of range");
  a_reset_restart: assert property (ALARM_O && rst_wr && !$past(FAULT_BLOCK_I, 2) |=> MOTOR_RUN_O)
    else $error("fault reset did not restart");
  a_derate_temp: assert property (DERATE_O == (TELEM_I.mod_temp > TEMP_LIMIT)) else $error("derate wrong");
  a_ramp_step: assert property (SPEED_REF_O > $past(SPEED_REF_O)
    |-> SPEED_REF_O == $past(SPEED_REF_O) + 16'h0001) else $error("ramp step too large");
  c_read: cover property (RVALID_O);
  c_refuse: cover property (WERR_O);
  c_stop: cover property ($fell(MOTOR_RUN_O));
endmodule
bind fdr_register_bank fdr_register_bank_assertions #(.TEMP_LIMIT(TEMP_LIMIT)) u_chk (.SYS_CLK_I, .NRST_I,
  .REQ_I, .TELEM_I, .FAULT_BLOCK_I, .RVALID_O, .WERR_O, .LINE_RATE_O, .FRAMING_O, .LOOP_REF_O, .SPEED_REF_O, .DERATE_O,
  .MOTOR_RUN_O, .ALARM_O);
`default_nettype wire

// file: dv/fdr_bus_master.sv
// partner: field-bus master model issuing one register access at a time
`timescale 1ns/10ps
`default_nettype none
module fdr_bus_master (
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic werr_i,
  input wire logic [15:0] rdata_i,
  output var fdr_pkg::fdr_req_t req_o,
  output logic link_o
);
  initial begin
    req_o = '0;
    link_o = 1'b0;
  end
  // callers may send threshold writes above the speed range; the bank refuses them
  task automatic access(input logic w, input logic sp, input logic [5:0] a, input logic [15:0] d,
      output logic [15:0] q, output logic f);
    q = 16'h0000;
    f = 1'b0;
    @(negedge clk_i);
    req_o = '{wr: w, rd: !w, input_space: sp, addr: a, wdata: d};
    @(negedge clk_i);
    // released lines show the inverse, so nothing may lean on a stale value
    req_o = '{wr: 1'b0, rd: 1'b0, input_space: !sp, addr: ~a, wdata: ~d};
    repeat (2) begin
      if (rvalid_i === 1'b1) q = rdata_i;
      if (rvalid_i === 1'b1 || werr_i === 1'b1) f = 1'b1;
      @(negedge clk_i);
    end
  endtask
  // one cycle of traffic from another station on the line
  task automatic pulse_link();
    @(negedge clk_i);
    link_o = 1'b1;
    @(negedge clk_i);
    link_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/fdr_register_bank_bench.sv
// bench: self-checking testbench of the fan driver register bank
`timescale 1ns/10ps
`default_nettype none
module fdr_register_bank_bench;
  // identity values are arbitrary
  localparam logic [15:0] FW_ID = 16'h0A01;
  localparam logic [15:0] DRV_ID = 16'h0B02;
  localparam logic [15:0] FAN_ID = 16'h0003;
  localparam logic [15:0] T_LIM = 16'h0320;
  int bad_count = 0;
  int compares = 0;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic fb = 1'b0;
  logic fa = 1'b0;
  logic dfail = 1'b0;
  logic [15:0] fcode = 16'h0002;
  // target, min, max, speed, bus, current, voltage, analog, temp, enable, ref, transducer, power, in current
  fdr_pkg::fdr_telem_t tel = '{16'h0200, 16'h0100, 16'h0800, 16'h01F4, 16'h0F01, 16'h0F02, 16'h0F03,
    16'h0F04, 16'h0300, 16'hC001, 16'hC002, 16'hC003, 16'h0F05, 16'h0F06};
  fdr_pkg::fdr_req_t req;
  logic link, rvalid, werr, lact, thr, der, run, alm;
  logic [15:0] rdata, rate, frm, lref, gp, gi, gd, per, sref;
  always #4 clk = ~clk;
  // shortened second, restart and ramp counts keep the run brief
  fdr_register_bank #(.FW_VERSION(FW_ID), .DRIVER_MODEL(DRV_ID), .FAN_MODEL(FAN_ID), .TEMP_LIMIT(T_LIM),
    .SECOND_CYCLES(100), .RESTART_CYCLES(50), .RAMP_CYCLES(4)) u_dut (.SYS_CLK_I(clk), .NRST_I(nrst),
    .REQ_I(req), .LINK_ACTIVITY_I(link), .TELEM_I(tel), .FAULT_BLOCK_I(fb), .FAULT_AUTO_I(fa),
    .FAULT_CODE_I(fcode), .DERATE_FAILED_I(dfail), .RDATA_O(rdata), .RVALID_O(rvalid), .WERR_O(werr),
    .LINE_RATE_O(rate), .FRAMING_O(frm), .LOOP_REF_O(lref), .LOOP_REF_ACTIVE_O(lact), .GAIN_P_O(gp),
    .GAIN_I_O(gi), .GAIN_D_O(gd), .LOOP_PERIOD_O(per), .SPEED_REF_O(sref), .THRESHOLD_O(thr),
    .DERATE_O(der), .MOTOR_RUN_O(run), .ALARM_O(alm));
  fdr_bus_master u_master (.clk_i(clk), .rvalid_i(rvalid), .werr_i(werr), .rdata_i(rdata), .req_o(req),
    .link_o(link));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic e, input logic sp = 1'b0);
    logic [15:0] q;
    logic f;
    u_master.access(1'b1, sp, a, d, q, f);
    chk({15'h0, f}, {15'h0, e}, "write refusal");
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp, input logic sp = 1'b1);
    logic [15:0] q;
    logic f;
    u_master.access(1'b0, sp, a, 16'h0000, q, f);
    chk({15'h0, f}, 16'h0001, "read answer");
    chk(q, exp, "read data");
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_reset();
    chk(sref, 16'h0100, "ramp start");
    chk(rate, 16'h0060, "rate default");
    chk(frm | lref | gp | gi | gd | per, 16'h0000, "defaults");
    rd(6'h38, 16'h0000, 1'b0);
    rd(6'h1D, T_LIM, 1'b0);
    rd(6'h2C, FAN_ID, 1'b0);
    rd(6'h00, FW_ID);
    rd(6'h01, DRV_ID);
    chk({15'h0, sref > 16'h0100 && sref < 16'h010A}, 16'h0001, "ramp rising");
  endtask
  task automatic t_fields();
    wr(6'h2F, 16'h00C0, 1'b0);
    wr(6'h2F, 16'h0064, 1'b1);
    chk(rate, 16'h00C0, "rate");
    for (int i = 0; i < 4; i++) wr(6'h30, 16'(i), i == 3);
    chk(frm, 16'h0002, "framing");
    wr(6'h32, 16'h0065, 1'b1);
    wr(6'h32, 16'h0064, 1'b0);
    chk({lref[14:0], lact}, 16'h00C8, "reference idle");
    wr(6'h22, 16'h000D, 1'b1);
    wr(6'h22, 16'h000C, 1'b0);
    chk({15'h0, lact}, 16'h0001, "reference active");
    for (int i = 0; i < 4; i++) begin
      wr(6'(6'h33 + i), 16'h8000, 1'b1);
      wr(6'(6'h33 + i), 16'h7FFF, 1'b0);
    end
    chk(gp & gi & gd & per, 16'h7FFF, "gains");
    wr(6'h03, 16'h0001, 1'b1, 1'b1);
    wr(6'h2C, 16'h0001, 1'b1);
    wr(6'h3F, 16'h0001, 1'b1);
    rd(6'h3F, 16'h0000, 1'b0);
  endtask
  task automatic t_thresh();
    wr(6'h37, 16'h0801, 1'b1);
    wr(6'h37, 16'h01F4, 1'b0);
    chk({15'h0, thr}, 16'h0000, "speed at threshold");
    tel.meas_speed = 16'h01F5;
    idle(3);
    chk({15'h0, thr}, 16'h0001, "speed over threshold");
    wr(6'h37, 16'h0000, 1'b0);
    chk({15'h0, thr}, 16'h0000, "threshold off");
  endtask
  task automatic t_telem();
    rd(6'h03, 16'h01F5);
    rd(6'h0F, 16'h0300);
    rd(6'h1C, 16'hC001);
    rd(6'h1D, 16'hC002);
    rd(6'h1E, 16'hC003);
    rd(6'h20, 16'h0F06);
    rd(6'h09, 16'h0F01);
    rd(6'h0C, 16'h0F02);
    rd(6'h0D, 16'h0F03);
    rd(6'h0E, 16'h0F04);
    rd(6'h1F, 16'h0F05);
  endtask
  task automatic t_link();
    wr(6'h38, 16'h8078, 1'b0);
    wr(6'h38, 16'h8079, 1'b1);
    wr(6'h38, 16'h0002, 1'b0);
    idle(150);
    u_master.pulse_link();
    idle(190);
    chk({15'h0, run}, 16'h0001, "still running");
    idle(20);
    chk({14'h0, run, alm}, 16'h0001, "link loss stop");
    rd(6'h0A, 16'h0004);
    rd(6'h11, 16'h00FF);
    wr(6'h00, 16'h0002, 1'b1);
    chk({15'h0, run}, 16'h0000, "loss blocks");
    wr(6'h00, 16'h0001, 1'b0);
    wr(6'h38, 16'h0000, 1'b0);
    rd(6'h0A, 16'h0000);
    idle(300);
    chk({15'h0, run}, 16'h0001, "timeout off");
  endtask
  task automatic t_faults();
    fb = 1'b1;
    idle(4);
    fb = 1'b0;
    rd(6'h0A, 16'h0002);
    idle(100);
    chk({15'h0, run}, 16'h0000, "blocked");
    wr(6'h00, 16'h0001, 1'b0);
    chk({15'h0, run}, 16'h0001, "reset restarts");
    fa = 1'b1;
    idle(4);
    fa = 1'b0;
    idle(36);
    chk({15'h0, run}, 16'h0000, "retry wait");
    idle(30);
    chk({15'h0, run}, 16'h0001, "auto restart");
    tel.mod_temp = 16'h0321;
    dfail = 1'b1;
    idle(6);
    chk({14'h0, der, run}, 16'h0002, "overheat stop");
    rd(6'h11, 16'h0071);
    tel.mod_temp = T_LIM;
    dfail = 1'b0;
    idle(6);
    chk({14'h0, der, run}, 16'h0000, "at limit still stopped");
    tel.mod_temp = 16'h031F;
    idle(6);
    chk({14'h0, der, run}, 16'h0001, "cooled restart");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // the whole sequence needs about 1100 cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  initial begin
    idle(3);
    nrst = 1'b1;
    @(negedge clk);
    t_reset();
    t_fields();
    t_thresh();
    t_telem();
    t_link();
    t_faults();
    finish_test();
  end
endmodule
`default_nettype wire
